// [src/fifo_flag_defs.vh]
// Constants for the FIFO error and limit flag block.
// Assumes inclusion by bare name from the block's design files.
`ifndef FIFO_FLAG_DEFS_VH
`define FIFO_FLAG_DEFS_VH

// Register indices on the plain register port.
`define REG_FLAG_STATUS   4'h0
`define REG_FIFO_CTRL     4'h1
`define REG_UPPER_LIMIT   4'h2
`define REG_CHAN_LIMIT_EN 4'h3
`define REG_EVT_STATUS    4'h4
`define REG_EVT_MASK      4'h5
`define REG_FILL_COUNT    4'h6

// Flag bit positions in the status byte.
`define BIT_MAIN_ERR      7
`define BIT_STORE_FAIL    6
`define BIT_FETCH_FAIL    5
`define BIT_UPPER_LIMIT   4

// Control register fields.
`define CTRL_MODE_HI      17
`define CTRL_MODE_LO      16
`define CTRL_STORE_IEN    14
`define CTRL_FETCH_IEN    13
`define CTRL_UPPER_IEN    12
`define CTRL_WM_HI        7
`define CTRL_WM_LO        0
`define CTRL_RESET        32'h00000000

// FIFO mode encodings.
`define MODE_DISABLED     2'h0
`define MODE_WATERMARK    2'h1

// Watermark field value that stands for the whole FIFO.
`define WM_FULL_CODE      8'h00
`define WM_FULL_COUNT     9'h100

// Flag order inside the three-bit flag vector.
`define FV_UPPER          0
`define FV_FETCH          1
`define FV_STORE          2

`endif

// [src/flag_cell.v]
// Bank of sticky flags where a set in the same cycle beats a clear.
// Assumes a synchronous active-low reset copy from the parent.
`timescale 1ns/1ps
`default_nettype none

module flag_cell #(
  parameter N = 3
) (
  input  wire         clk,     // System clock.
  input  wire         rst_n,   // Synchronised reset, active low.
  input  wire [N-1:0] set,     // Set requests.
  input  wire [N-1:0] clr,     // Clear requests.
  output wire [N-1:0] flag     // Flag levels.
);

  reg [N-1:0] flag_q;
  reg [N-1:0] flag_d;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_bit
      always @* begin
        if (set[i]) begin
          flag_d[i] = 1'b1;
        end else if (clr[i]) begin
          flag_d[i] = 1'b0;
        end else begin
          flag_d[i] = flag_q[i];
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= {N{1'b0}};
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule

`default_nettype wire

// [src/fifo_error_threshold_flags.v]
// Error and upper-limit flags for a sample FIFO, with a fill tracker.
// Assumes conversion, pop and host read strobes synchronous to sys_clk,
// and an external FIFO store that obeys store_accept.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

`include "fifo_flag_defs.vh"

module fifo_error_threshold_flags #(
  parameter DATA_W  = 16,
  parameter CHAN_N  = 16,
  parameter CHAN_W  = 4,
  parameter DEPTH   = 256,
  parameter ERR_N   = 8
) (
  input  wire              sys_clk,         // System clock, 20 MHz.
  input  wire              rst_n,           // Asynchronous reset, low.
  input  wire [3:0]        reg_addr,        // Register index.
  input  wire [31:0]       reg_wdata,       // Register write data.
  input  wire              reg_wr,          // Write strobe.
  input  wire              reg_rd,          // Read strobe.
  output wire [31:0]       reg_rdata,       // Read data, next cycle.
  input  wire [ERR_N-1:0]  err_bits,        // Error register bits.
  output wire              main_err_status, // Summary to general status.
  input  wire              conv_valid,      // Conversion ready to store.
  input  wire [DATA_W-1:0] conv_data,       // Conversion result.
  input  wire [CHAN_W-1:0] conv_chan,       // Conversion channel.
  output wire              store_accept,    // Conversion goes to FIFO.
  input  wire              read_busy,       // FIFO read in progress.
  input  wire              fetch_req,       // Host FIFO read request.
  output wire              fetch_grant,     // Request granted.
  output wire              fetch_refused,   // Request refused.
  input  wire              sample_pop,      // One sample drained.
  output wire              fifo_empty,      // Fill count is zero.
  output wire              irq              // Interrupt, active high.
);

  reg  [1:0]        rst_sync_q;
  wire              rst_s_n;
  reg  [31:0]       ctrl_q;
  reg  [DATA_W-1:0] upper_limit_value_q;
  reg  [CHAN_N-1:0] channel_limit_check_enable_q;
  reg  [2:0]        evt_q;
  reg  [2:0]        evt_d;
  reg  [2:0]        mask_q;
  reg  [8:0]        fill_q;
  reg  [8:0]        fill_d;
  reg               wm_lock_q;
  reg               wm_lock_d;
  reg               main_err_q;
  reg  [31:0]       rdata_q;
  reg  [31:0]       rdata_d;
  wire [1:0]        mode;
  wire              active;
  wire              wm_mode;
  wire [8:0]        wm_count;
  wire              full;
  wire              pop_ok;
  wire              becomes_empty;
  wire              store_fail;
  wire              upper_hit;
  wire [2:0]        flag_set;
  wire [2:0]        flag_clr;
  wire [2:0]        flags;
  wire [2:0]        flag_ien;
  wire [7:0]        status_byte;
  wire [2:0]        flag_irq;
  wire              wr_ctrl;
  wire              wr_limit;
  wire              wr_chan_en;
  wire              wr_evt;
  wire              wr_mask;

  localparam [8:0] DEPTH_C = DEPTH[8:0];

  // Index compare shared by every write decode below.
  function reg_hit;
    input [3:0] addr;
    input [3:0] index;
    begin
      reg_hit = (addr == index);
    end
  endfunction

  // Reset is released through two flops so release is glitch-free.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_q[1];

  assign mode    = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign active  = (mode != `MODE_DISABLED);
  assign wm_mode = (mode == `MODE_WATERMARK);

  assign wm_count = (ctrl_q[`CTRL_WM_HI:`CTRL_WM_LO] == `WM_FULL_CODE) ?
                    `WM_FULL_COUNT : {1'b0, ctrl_q[`CTRL_WM_HI:`CTRL_WM_LO]};

  assign full   = (fill_q == DEPTH_C);
  assign pop_ok = sample_pop && (fill_q != 9'h000);

  assign store_fail = active && conv_valid &&
                      (read_busy || (wm_mode && (wm_lock_q || full)));
  assign store_accept = active && conv_valid && !store_fail;

  // In streaming mode a full FIFO drops its oldest sample, so the
  // count holds at depth instead of refusing the store.
  always @* begin
    fill_d = fill_q;
    if (store_accept && !pop_ok && !full) begin
      fill_d = fill_q + 9'h001;
    end else if (pop_ok && !(store_accept)) begin
      fill_d = fill_q - 9'h001;
    end
  end

  assign becomes_empty = (fill_q != 9'h000) && (fill_d == 9'h000);
  assign fifo_empty    = (fill_q == 9'h000);

  // The lock is what makes the FIFO look full at the watermark; a partial
  // drain does not release it, only an empty FIFO or leaving watermark mode does.
  // lock at watermark until empty
  always @* begin
    wm_lock_d = wm_lock_q;
    if (wm_mode && store_accept && (fill_d >= wm_count)) begin
      wm_lock_d = 1'b1;
    end else if (becomes_empty || !wm_mode) begin
      wm_lock_d = 1'b0;
    end
  end

  // A fetch that collides with a store is refused, not stalled, so the
  // host has to retry it; outside an active mode nothing is refused.
  // refuse fetch during a write
  assign fetch_refused = fetch_req && conv_valid && active;
  assign fetch_grant   = fetch_req && !fetch_refused;

  // The compare is unsigned; a bipolar result must be offset first.
  // limit compare on stored samples
  assign upper_hit = store_accept &&
                     channel_limit_check_enable_q[conv_chan] &&
                     (conv_data >= upper_limit_value_q);

  // sets only in an active mode
  assign flag_set[`FV_UPPER] = active && upper_hit;
  assign flag_set[`FV_FETCH] = active && fetch_refused;
  assign flag_set[`FV_STORE] = active && store_fail;
  assign flag_clr[`FV_STORE] = becomes_empty;
  // fetch clears on grant or empty
  assign flag_clr[`FV_FETCH] = becomes_empty || fetch_grant;
  assign flag_clr[`FV_UPPER] = becomes_empty;

  flag_cell #(
    .N     (3)
  ) u_flags (
    .clk   (sys_clk),
    .rst_n (rst_s_n),
    .set   (flag_set),
    .clr   (flag_clr),
    .flag  (flags)
  );

  assign flag_ien = {ctrl_q[`CTRL_STORE_IEN], ctrl_q[`CTRL_FETCH_IEN],
                     ctrl_q[`CTRL_UPPER_IEN]};

  assign flag_irq = flags & flag_ien;

  // Either path alone, flag enable or event mask, holds the pin high.
  // level follows flag
  assign irq = (|flag_irq) || (|(evt_q & mask_q));

  // The summary is registered, so it trails the error bits by a cycle.
  // summary of error register
  assign main_err_status = main_err_q;

  assign status_byte = {main_err_q, flags[`FV_STORE], flags[`FV_FETCH],
                        flags[`FV_UPPER], 4'h0};

  // Event bits are sticky and cleared by writing one; a new event wins.
  always @* begin
    evt_d = evt_q;
    if (wr_evt) begin
      evt_d = evt_q & ~reg_wdata[2:0];
    end
    evt_d = evt_d | flag_set;
  end

  always @* begin
    rdata_d = 32'h00000000;
    if (reg_addr == `REG_FLAG_STATUS) begin
      rdata_d = {24'h000000, status_byte};
    end else if (reg_addr == `REG_FIFO_CTRL) begin
      rdata_d = ctrl_q;
    end else if (reg_addr == `REG_UPPER_LIMIT) begin
      rdata_d[DATA_W-1:0] = upper_limit_value_q;
    end else if (reg_addr == `REG_CHAN_LIMIT_EN) begin
      rdata_d[CHAN_N-1:0] = channel_limit_check_enable_q;
    end else if (reg_addr == `REG_EVT_STATUS) begin
      rdata_d[2:0] = evt_q;
    end else if (reg_addr == `REG_EVT_MASK) begin
      rdata_d[2:0] = mask_q;
    end else if (reg_addr == `REG_FILL_COUNT) begin
      rdata_d[8:0] = fill_q;
    end
  end

  assign wr_ctrl    = reg_wr && reg_hit(reg_addr, `REG_FIFO_CTRL);
  assign wr_limit   = reg_wr && reg_hit(reg_addr, `REG_UPPER_LIMIT);
  assign wr_chan_en = reg_wr && reg_hit(reg_addr, `REG_CHAN_LIMIT_EN);
  assign wr_evt     = reg_wr && reg_hit(reg_addr, `REG_EVT_STATUS);
  assign wr_mask    = reg_wr && reg_hit(reg_addr, `REG_EVT_MASK);

  // Configuration registers; bit 15 of the control word is reserved
  // and kept at zero whatever the host writes there.
  always @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ctrl_q                       <= `CTRL_RESET;
      upper_limit_value_q          <= {DATA_W{1'b0}};
      channel_limit_check_enable_q <= {CHAN_N{1'b0}};
      mask_q                       <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {14'h0000, reg_wdata[17:16], 1'b0, reg_wdata[14:0]};
      end
      if (wr_limit) begin
        upper_limit_value_q <= reg_wdata[DATA_W-1:0];
      end
      if (wr_chan_en) begin
        channel_limit_check_enable_q <= reg_wdata[CHAN_N-1:0];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  always @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      fill_q    <= 9'h000;
      wm_lock_q <= 1'b0;
    end else begin
      fill_q    <= fill_d;
      wm_lock_q <= wm_lock_d;
    end
  end

  always @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      evt_q <= 3'h0;
    end else begin
      evt_q <= evt_d;
    end
  end

  // Read data are zero outside the answer cycle, so a late sample of the
  // bus shows nothing stale.
  always @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      main_err_q <= 1'b0;
      rdata_q    <= 32'h00000000;
    end else begin
      main_err_q <= |err_bits;
      rdata_q    <= reg_rd ? rdata_d : 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// [test/flags_chk.sv]
// Port-level checks for the FIFO error and upper-limit flag block.
// Assumes the block's internal reset leaves two edges after rst_n rises.
`timescale 1ns/1ps
`default_nettype none
module flags_chk #(
  parameter ERR_N = 8
) (
  input wire logic             sys_clk,         // Clock.
  input wire logic             rst_n,           // Reset, low.
  input wire logic             reg_rd,          // Read strobe.
  input wire logic             reg_wr,          // Write strobe.
  input wire logic [31:0]      reg_rdata,       // Read data.
  input wire logic [ERR_N-1:0] err_bits,        // Error bits.
  input wire logic             main_err_status, // Summary out.
  input wire logic             conv_valid,      // Conversion.
  input wire logic             store_accept,    // Store taken.
  input wire logic             read_busy,       // Read busy.
  input wire logic             fetch_req,       // Fetch request.
  input wire logic             fetch_grant,     // Fetch granted.
  input wire logic             fetch_refused,   // Fetch refused.
  input wire logic             sample_pop,      // Drain pulse.
  input wire logic             fifo_empty,      // Empty.
  input wire logic             irq              // Interrupt.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_main_err_follow: assert property (
    main_err_status == $past(|err_bits)) else $error("summary bit wrong");
  chk_store_busy_block: assert property (
    conv_valid && read_busy |-> !store_accept) else $error("store in read");
  chk_store_fills_fifo: assert property (
    store_accept |-> conv_valid ##1 !fifo_empty)
    else $error("store left FIFO empty");
  chk_refuse_cause: assert property (
    fetch_refused |-> fetch_req && conv_valid && !fetch_grant)
    else $error("refusal without cause");
  chk_grant_free: assert property (
    fetch_req && !conv_valid |-> fetch_grant) else $error("grant missing");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data stray");
  chk_empty_leave: assert property (
    fifo_empty && store_accept && !sample_pop |=> !fifo_empty)
    else $error("empty after store");
  chk_empty_stay: assert property (
    fifo_empty && !store_accept |=> fifo_empty) else $error("empty lost");
  chk_irq_rise_cause: assert property (
    $rose(irq) |-> $past(conv_valid || fetch_req || reg_wr))
    else $error("interrupt rose alone");
  chk_irq_fall_cause: assert property (
    $fell(irq) |-> $past(sample_pop || fetch_req || reg_wr))
    else $error("interrupt fell alone");
  cover property (fetch_refused);
  cover property (conv_valid && !store_accept);
  cover property ($fell(irq));
endmodule
bind fifo_error_threshold_flags flags_chk #(.ERR_N(ERR_N)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .err_bits(err_bits),
  .main_err_status(main_err_status), .conv_valid(conv_valid),
  .store_accept(store_accept), .read_busy(read_busy),
  .fetch_req(fetch_req), .fetch_grant(fetch_grant),
  .fetch_refused(fetch_refused), .sample_pop(sample_pop),
  .fifo_empty(fifo_empty), .irq(irq));
`default_nettype wire

// [test/host_drain.sv]
// Host side model that drains the FIFO one sample per cycle.
// Assumes go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module host_drain (
  input  wire logic       clk,        // Clock.
  input  wire logic       rst_n,      // Reset, low.
  input  wire logic       go,         // Start draining.
  input  wire logic [8:0] n,          // Samples to drain.
  output wire logic       sample_pop  // Drain pulse.
);
  logic [8:0] left_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) left_q <= 9'h000;
    else if (go) left_q <= n;
    else if (left_q != 9'h000) left_q <= left_q - 9'h001;
  end
  assign sample_pop = (left_q != 9'h000);
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Bench for the FIFO flag block with a draining host model.
// Assumes the register port answers reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst_n, reg_wr, reg_rd, conv_valid, read_busy;
  logic fetch_req, go, sample_pop, store_accept, fetch_grant;
  logic fetch_refused, fifo_empty, irq, main_err_status;
  logic [3:0] reg_addr, conv_chan;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] err_bits;
  logic [15:0] conv_data;
  logic [8:0] n;
  int errors, samples_checked, cyc;
  fifo_error_threshold_flags dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_bits(err_bits),
    .main_err_status(main_err_status), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_chan(conv_chan),
    .store_accept(store_accept), .read_busy(read_busy),
    .fetch_req(fetch_req), .fetch_grant(fetch_grant),
    .fetch_refused(fetch_refused), .sample_pop(sample_pop),
    .fifo_empty(fifo_empty), .irq(irq));
  host_drain host (.clk(sys_clk), .rst_n(rst_n), .go(go), .n(n),
    .sample_pop(sample_pop));
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk); reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk); reg_rd <= 1; reg_addr <= a;
    @(posedge sys_clk); reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task conv(input logic [15:0] d, input logic [3:0] c, input logic b);
    @(posedge sys_clk); conv_valid <= 1; conv_data <= d; conv_chan <= c;
    read_busy <= b;
    @(posedge sys_clk); conv_valid <= 0; read_busy <= 0;
  endtask
  task fetch(input logic cv, input logic e);
    @(posedge sys_clk); fetch_req <= 1; conv_valid <= cv;
    #1 chk(fetch_refused, e);
    @(posedge sys_clk); fetch_req <= 0; conv_valid <= 0;
  endtask
  task drain(input logic [8:0] k);
    @(posedge sys_clk); go <= 1; n <= k;
    @(posedge sys_clk); go <= 0;
    repeat (k + 2) @(posedge sys_clk);
    #1;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Generous ceiling; the whole sequence takes about 915 cycles.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, conv_valid, read_busy, fetch_req, go} <= 0;
    {reg_addr, conv_chan, reg_wdata, err_bits, conv_data, n} <= 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    repeat (3) @(posedge sys_clk);
    rd(4'h1, 32'h0);
    rd(4'hF, 32'h0);
    conv(16'hFFFF, 4'h0, 1);
    rd(4'h0, 32'h0);
    rd(4'h6, 32'h0);
    $display("test reset and disabled mode done");
    wr(4'h2, 32'h0100);
    wr(4'h3, 32'h0001);
    wr(4'h1, 32'h00017002);
    conv(16'h00FF, 4'h0, 0);
    rd(4'h0, 32'h0);
    conv(16'h0100, 4'h0, 0);
    rd(4'h0, 32'h10);
    chk(irq, 1);
    rd(4'h6, 32'h2);
    conv(16'h0000, 4'h1, 0);
    rd(4'h0, 32'h50);
    wr(4'h0, 32'hFF);
    rd(4'h0, 32'h50);
    fetch(1, 1);
    rd(4'h0, 32'h70);
    fetch(0, 0);
    rd(4'h0, 32'h50);
    drain(2);
    chk({irq, fifo_empty}, 2'b01);
    rd(4'h0, 32'h0);
    $display("test watermark mode done");
    wr(4'h1, 32'h00010000);
    repeat (256) conv(16'h0000, 4'h1, 0);
    rd(4'h6, 32'h100);
    rd(4'h0, 32'h0);
    conv(16'h0000, 4'h1, 0);
    rd(4'h0, 32'h40);
    drain(9'h100);
    rd(4'h0, 32'h0);
    $display("test full watermark code done");
    for (int m = 2; m < 4; m++) begin
      wr(4'h1, {14'h0, m[1:0], 16'h0002});
      repeat (3) conv(16'h0000, 4'h1, 0);
      rd(4'h0, 32'h0);
      conv(16'h0000, 4'h1, 1);
      rd(4'h0, 32'h40);
      chk(irq, 0);
      wr(4'h5, 32'h4);
      #1 chk(irq, 1);
      wr(4'h4, 32'h4);
      #1 chk(irq, 0);
      wr(4'h1, {14'h0, m[1:0], 16'h4002});
      #1 chk(irq, 1);
      drain(3);
      chk(irq, 0);
      wr(4'h5, 32'h0);
      $display("test streaming mode done");
    end
    wr(4'h1, 32'h00032000);
    fetch(1, 1);
    #1 chk(irq, 1);
    fetch(0, 0);
    #1 chk(irq, 0);
    $display("test fetch interrupt done");
    err_bits <= 8'h04;
    repeat (2) @(posedge sys_clk);
    #1 chk(main_err_status, 1);
    rd(4'h0, 32'h80);
    err_bits <= 8'h00;
    $display("test summary error done");
    final_report;
  end
endmodule
`default_nettype wire
